// >>> common/psv_regs.svh
// Purpose: Named constants for the program sequencer
// Assumes: Included by the package and by each design file
// Notes: Addresses are 10-bit program word addresses
`ifndef PSV_REGS_SVH
`define PSV_REGS_SVH

`define PSV_PC_W 10
`define PSV_INSTR_W 13
`define PSV_STACK_DEPTH 5
`define PSV_DEPTH_W 3
`define PSV_PORT_W 8
`define PSV_NUM_SRC 3

`define PSV_RESET_VEC 10'h3ff
`define PSV_HW_VEC 10'h008
`define PSV_SW_VEC 10'h002
`define PSV_PC_STEP 10'h001
`define PSV_INSTR_NOP 13'h0000
`define PSV_DEPTH_FULL 3'h5
`define PSV_DEPTH_ONE 3'h1
`define PSV_DEPTH_EMPTY 3'h0

`define PSV_SRC_TICK 0
`define PSV_SRC_PORTB 1
`define PSV_SRC_EXT 2
`define PSV_EXT_INT_BIT 0
`define PSV_RESET_PIN_BIT 3
`define PSV_PB3_OE_NEVER 1'b0

`define PSV_OSC_IRC 2'h0
`define PSV_OSC_EXTERNAL_RC_MODE 2'h1
`define PSV_OSC_ERC 2'h2
`define PSV_OSC_XTAL 2'h3

`endif

// >>> common/psv_pkg.sv
// Purpose: Types shared by the sequencer and its return stack
// Assumes: psv_regs.svh on the include path
// Notes: All module state lives in the structs below
`include "psv_regs.svh"

package psv_pkg;

  typedef enum logic [2:0] {
    st_run = 3'h1,
    st_flush = 3'h2,
    st_sleep = 3'h4
  } psv_state_t;

  typedef struct packed {
    psv_state_t state;
    logic [`PSV_PC_W-1:0] pc;
    logic [`PSV_INSTR_W-1:0] instr;
    logic instr_valid;
    logic [`PSV_PORT_W-1:0] pb_s1;
    logic [`PSV_PORT_W-1:0] pb_s2;
    logic [`PSV_PORT_W-1:0] pb_prev;
    logic [`PSV_NUM_SRC-1:0] flags;
    logic cycle_rate_out;
    logic sys_rst;
  } psv_seq_t;

  typedef struct packed {
    logic [`PSV_STACK_DEPTH-1:0][`PSV_PC_W-1:0] ent;
    logic [`PSV_DEPTH_W-1:0] depth;
  } psv_stack_t;

  function automatic logic psv_is_rc_mode(input logic [1:0] mode);
    psv_is_rc_mode = (mode == `PSV_OSC_IRC) || (mode == `PSV_OSC_EXTERNAL_RC_MODE) || (mode == `PSV_OSC_ERC);
  endfunction : psv_is_rc_mode

endpackage : psv_pkg

// >>> hdl/psv_ret_stack.sv
// Purpose: Five-entry return address stack
// Assumes: Push and pop never in the same cycle
// Notes: A push when full drops the oldest entry
`timescale 1ns/1ps
`default_nettype none
`include "psv_regs.svh"

module psv_ret_stack
  import psv_pkg::*;
(
  input wire logic ref_clk_in,
  input wire logic nrst_in,
  input wire logic push_in,
  input wire logic pop_in,
  input wire logic [`PSV_PC_W-1:0] push_addr_in,
  output logic [`PSV_PC_W-1:0] top_out,
  output logic [`PSV_DEPTH_W-1:0] depth_out
);

  psv_stack_t q;
  psv_stack_t next_q;

  always_comb begin
    next_q = q;
    if (push_in) begin
      next_q.ent[0] = push_addr_in;
      for (int i = 1; i < `PSV_STACK_DEPTH; i++) begin
        next_q.ent[i] = q.ent[i-1];
      end
      if (q.depth != `PSV_DEPTH_FULL) begin
        next_q.depth = q.depth + `PSV_DEPTH_ONE;
      end
    end else if (pop_in) begin
      for (int i = 0; i < `PSV_STACK_DEPTH - 1; i++) begin
        next_q.ent[i] = q.ent[i+1];
      end
      // Underflow returns stale data, as on the real stack
      if (q.depth != `PSV_DEPTH_EMPTY) begin
        next_q.depth = q.depth - `PSV_DEPTH_ONE;
      end
    end
  end

  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  assign top_out = q.ent[0];
  assign depth_out = q.depth;

  stack_full_hold_a: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
    push_in && (depth_out == `PSV_DEPTH_FULL) |=> depth_out == `PSV_DEPTH_FULL)
    else $error("stack depth left five on push while full");

  stack_push_top_a: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
    push_in |=> top_out == $past(push_addr_in))
    else $error("pushed address not on top");

endmodule : psv_ret_stack
`default_nettype wire

// >>> hdl/psv_sequencer.sv
// Purpose: Program sequencer, vectors and wake-up for the 8-bit core
// Assumes: Program store reads combinationally; core qualifies instr_out with instr_valid_out
// Notes: One clock is the instruction cycle
//
// What this block does
// - Every instruction takes one cycle and every branch takes two.
// - Each fetched instruction word is 13 bits and one word is one instruction.
// - A five-entry return stack serves calls and interrupts.
// - Any reset loads the program counter with 3FFh and runs from there.
// - A hardware interrupt loads the program counter with 008h.
// - A software interrupt loads the program counter with 002h.
// - Calls and jumps reach any of the 1K words directly with no paging.
// - Interrupts come from tick counter overflow, the external pin edge and port B change.
// - Sleep ends on external pin activity or a port B input change.
// - With port B bit 3 used as reset, a low level resets and a weak pull-up is on.
// - Port B bit 3 is input only and still wakes the core.
// - In RC modes the oscillator output pin may carry a square wave at half the cycle rate.
`timescale 1ns/1ps
`default_nettype none
`include "psv_regs.svh"

module psv_sequencer
  import psv_pkg::*;
(
  input wire logic ref_clk_in,
  input wire logic nrst_in,
  input wire logic por_rst_in,
  input wire logic bor_rst_in,
  input wire logic wdt_rst_in,
  output logic [`PSV_PC_W-1:0] prog_addr_out,
  input wire logic [`PSV_INSTR_W-1:0] prog_data_in,
  output logic [`PSV_INSTR_W-1:0] instr_out,
  output logic instr_valid_out,
  input wire logic jump_in,
  input wire logic call_in,
  input wire logic ret_in,
  input wire logic swi_in,
  input wire logic sleep_in,
  input wire logic [`PSV_PC_W-1:0] target_in,
  input wire logic tick_ovf_in,
  input wire logic [`PSV_PORT_W-1:0] port_b_in,
  input wire logic [`PSV_PORT_W-1:0] port_b_wake_en_in,
  input wire logic int_edge_rise_in,
  input wire logic gie_in,
  input wire logic [`PSV_NUM_SRC-1:0] int_en_in,
  input wire logic [`PSV_NUM_SRC-1:0] flag_clr_in,
  output logic [`PSV_NUM_SRC-1:0] int_flags_out,
  output logic int_taken_out,
  output logic sleeping_out,
  output logic sys_reset_out,
  input wire logic ext_reset_sel_in,
  output logic port_b_bit3_pullup_out,
  output logic port_b_bit3_oe_out,
  input wire logic [1:0] osc_mode_in,
  input wire logic cycle_rate_out_en_in,
  output logic osc_out_pin_out,
  output logic osc_out_pin_oe_out
);

  psv_seq_t q;
  psv_seq_t next_q;
  logic [`PSV_PC_W-1:0] stack_top;
  logic [`PSV_DEPTH_W-1:0] stack_depth;
  logic rst_any;
  logic exec;
  logic take_jump;
  logic take_call;
  logic take_ret;
  logic take_sw;
  logic take_hw;
  logic take_sleep;
  logic ext_edge;
  logic [`PSV_PORT_W-1:0] pb_change;
  logic wake;
  logic irq_pending;
  logic [`PSV_NUM_SRC-1:0] flag_set;
  logic rc_out_on;

  always_comb begin
    // Reset pin is only sampled after both sync stages
    rst_any = por_rst_in || bor_rst_in || wdt_rst_in ||
      (ext_reset_sel_in && !q.pb_s2[`PSV_RESET_PIN_BIT]);
    exec = (q.state == st_run) && q.instr_valid;
    ext_edge = int_edge_rise_in ?
      (q.pb_s2[`PSV_EXT_INT_BIT] && !q.pb_prev[`PSV_EXT_INT_BIT]) :
      (!q.pb_s2[`PSV_EXT_INT_BIT] && q.pb_prev[`PSV_EXT_INT_BIT]);
    pb_change = (q.pb_s2 ^ q.pb_prev) & port_b_wake_en_in;
    flag_set = '0;
    flag_set[`PSV_SRC_TICK] = tick_ovf_in;
    flag_set[`PSV_SRC_PORTB] = |pb_change;
    flag_set[`PSV_SRC_EXT] = ext_edge;
    wake = ext_edge || (|pb_change);
    irq_pending = gie_in && |(q.flags & int_en_in);
    // Priority: the executing instruction's branch beats a waiting interrupt
    take_jump = !rst_any && exec && jump_in;
    take_call = !rst_any && exec && !jump_in && call_in;
    take_ret = !rst_any && exec && !jump_in && !call_in && ret_in;
    take_sw = !rst_any && exec && !jump_in && !call_in && !ret_in && swi_in;
    take_sleep = !rst_any && exec && !jump_in && !call_in && !ret_in && !swi_in && sleep_in;
    take_hw = !rst_any && exec && !jump_in && !call_in && !ret_in && !swi_in && !sleep_in && irq_pending;
    rc_out_on = cycle_rate_out_en_in && psv_is_rc_mode(osc_mode_in);
  end

  always_comb begin
    next_q = q;
    next_q.pb_s1 = port_b_in;
    next_q.pb_s2 = q.pb_s1;
    next_q.pb_prev = q.pb_s2;
    // Set wins over a clear in the same cycle
    next_q.flags = (q.flags & ~flag_clr_in) | flag_set;
    next_q.cycle_rate_out = rc_out_on ? !q.cycle_rate_out : 1'b0;
    next_q.sys_rst = rst_any;
    if (rst_any) begin
      next_q.pc = `PSV_RESET_VEC;
      next_q.state = st_flush;
      next_q.instr_valid = 1'b0;
      next_q.instr = `PSV_INSTR_NOP;
      next_q.flags = '0;
    end else begin
      case (q.state)
        st_run: begin
          next_q.instr = prog_data_in;
          next_q.instr_valid = 1'b1;
          next_q.pc = q.pc + `PSV_PC_STEP;
          if (take_jump || take_call) begin
            next_q.pc = target_in;
          end else if (take_ret) begin
            next_q.pc = stack_top;
          end else if (take_sw) begin
            next_q.pc = `PSV_SW_VEC;
          end else if (take_hw) begin
            next_q.pc = `PSV_HW_VEC;
          end
          if (take_jump || take_call || take_ret || take_sw || take_hw) begin
            next_q.state = st_flush;
            next_q.instr_valid = 1'b0;
          end else if (take_sleep) begin
            next_q.state = st_sleep;
            next_q.instr_valid = 1'b0;
            next_q.pc = q.pc;
          end
        end
        st_flush: begin
          next_q.instr = prog_data_in;
          next_q.instr_valid = 1'b1;
          next_q.pc = q.pc + `PSV_PC_STEP;
          next_q.state = st_run;
        end
        st_sleep: begin
          next_q.instr_valid = 1'b0;
          if (wake) begin
            next_q.state = st_flush;
          end
        end
        default: begin
          next_q.state = st_flush;
          next_q.instr_valid = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      q <= '{state: st_flush, pc: `PSV_RESET_VEC, instr: `PSV_INSTR_NOP, default: '0};
    end else begin
      q <= next_q;
    end
  end

  // Fetch address is already the next instruction's address
  psv_ret_stack u_stack (
    .ref_clk_in(ref_clk_in),
    .nrst_in(nrst_in),
    .push_in(take_call || take_sw || take_hw),
    .pop_in(take_ret),
    .push_addr_in(q.pc),
    .top_out(stack_top),
    .depth_out(stack_depth)
  );

  assign prog_addr_out = q.pc;
  assign instr_out = q.instr;
  assign instr_valid_out = q.instr_valid;
  assign int_flags_out = q.flags;
  assign int_taken_out = take_hw;
  assign sleeping_out = (q.state == st_sleep);
  assign sys_reset_out = q.sys_rst;
  assign port_b_bit3_pullup_out = ext_reset_sel_in;
  assign port_b_bit3_oe_out = `PSV_PB3_OE_NEVER;
  assign osc_out_pin_out = q.cycle_rate_out;
  assign osc_out_pin_oe_out = rc_out_on;

  reset_vector_load_a: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
    rst_any ##1 !rst_any |-> prog_addr_out == `PSV_RESET_VEC ##1 instr_valid_out)
    else $error("reset did not fetch from 3FFh");

  hw_vector_load_a: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
    take_hw |=> prog_addr_out == `PSV_HW_VEC && !instr_valid_out)
    else $error("hardware interrupt missed 008h");

  sw_vector_load_a: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
    take_sw |=> prog_addr_out == `PSV_SW_VEC)
    else $error("software interrupt missed 002h");

  branch_two_cycle_a: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
    take_jump && !por_rst_in ##1 !rst_any |-> !instr_valid_out ##1 instr_valid_out)
    else $error("branch did not take exactly two cycles");

  single_cycle_step_a: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
    exec && !rst_any && !take_jump && !take_call && !take_ret && !take_sw && !take_hw && !take_sleep
    |=> instr_valid_out && prog_addr_out == $past(prog_addr_out) + `PSV_PC_STEP)
    else $error("plain instruction took more than one cycle");

  fetch_word_kept_a: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
    (q.state == st_flush) && !rst_any |=> instr_out == $past(prog_data_in))
    else $error("fetched word not passed whole");

  jump_target_a: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
    take_jump || take_call |=> prog_addr_out == $past(target_in))
    else $error("branch target not reached directly");

  int_push_next_a: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
    take_hw |=> stack_top == $past(prog_addr_out))
    else $error("interrupt did not push next address");

  tick_flag_set_a: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
    tick_ovf_in && !rst_any |=> int_flags_out[`PSV_SRC_TICK])
    else $error("tick overflow flag lost");

  // A sync reset during the flush cycle legally keeps valid low
  sleep_wake_a: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
    sleeping_out && wake && !rst_any ##1 !rst_any |-> !sleeping_out ##1 instr_valid_out)
    else $error("sleep did not end on wake event");

  call_depth_grow_a: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
    take_call && (stack_depth != `PSV_DEPTH_FULL) |=> stack_depth == $past(stack_depth) + `PSV_DEPTH_ONE)
    else $error("call did not deepen return stack");

  rate_toggle_a: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
    rc_out_on ##1 rc_out_on |-> osc_out_pin_out != $past(osc_out_pin_out))
    else $error("cycle rate output not toggling");

endmodule : psv_sequencer
`default_nettype wire

// >>> tb/psv_prog_model.sv
// Purpose: Program store and tick counter facing the sequencer
// Assumes: Store reads are combinational
// Notes: Word pattern lets the bench predict every fetch
`timescale 1ns/1ps
`default_nettype none

module psv_prog_model (
  input wire logic ref_clk_in,
  input wire logic nrst_in,
  input wire logic run_in,
  input wire logic [9:0] addr_in,
  output logic [12:0] data_out,
  output logic ovf_out
);
  logic [7:0] cnt;
  assign data_out = {3'h5, addr_in};
  // Starts near the top so overflow comes soon
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) cnt <= 8'hfa;
    else if (run_in) cnt <= cnt + 8'h01;
  end
  assign ovf_out = run_in && (cnt == 8'hff);
endmodule : psv_prog_model

`default_nettype wire

// >>> tb/tb_program_sequencer_vectors.sv
// Purpose: Self-checking bench for the program sequencer
// Assumes: Inputs change on the falling edge
// Notes: Return addresses are tracked here, not read back
`timescale 1ns/1ps
`default_nettype none
`include "psv_regs.svh"

module tb_program_sequencer_vectors;
  import psv_pkg::*;
  logic ref_clk_in, nrst_in, por_rst_in, bor_rst_in, wdt_rst_in, jump_in, call_in, ret_in, swi_in, sleep_in;
  logic tick_ovf_in, int_edge_rise_in, gie_in, ext_reset_sel_in, cycle_rate_out_en_in, tick_run;
  logic instr_valid_out, int_taken_out, sleeping_out, sys_reset_out, port_b_bit3_pullup_out;
  logic port_b_bit3_oe_out, osc_out_pin_out, osc_out_pin_oe_out;
  logic [9:0] prog_addr_out, target_in, pc_exp;
  logic [12:0] prog_data_in, instr_out;
  logic [7:0] port_b_in, port_b_wake_en_in;
  logic [2:0] int_en_in, flag_clr_in, int_flags_out;
  logic [1:0] osc_mode_in;
  logic [9:0] stk[$];
  int miscompares = 0;
  int check_count = 0;

  psv_prog_model MEM (.ref_clk_in(ref_clk_in), .nrst_in(nrst_in), .run_in(tick_run),
    .addr_in(prog_addr_out), .data_out(prog_data_in), .ovf_out(tick_ovf_in));
  psv_sequencer DUT (.ref_clk_in(ref_clk_in), .nrst_in(nrst_in), .por_rst_in(por_rst_in),
    .bor_rst_in(bor_rst_in), .wdt_rst_in(wdt_rst_in), .prog_addr_out(prog_addr_out),
    .prog_data_in(prog_data_in), .instr_out(instr_out), .instr_valid_out(instr_valid_out),
    .jump_in(jump_in), .call_in(call_in), .ret_in(ret_in), .swi_in(swi_in), .sleep_in(sleep_in),
    .target_in(target_in), .tick_ovf_in(tick_ovf_in), .port_b_in(port_b_in),
    .port_b_wake_en_in(port_b_wake_en_in), .int_edge_rise_in(int_edge_rise_in), .gie_in(gie_in),
    .int_en_in(int_en_in), .flag_clr_in(flag_clr_in), .int_flags_out(int_flags_out),
    .int_taken_out(int_taken_out), .sleeping_out(sleeping_out), .sys_reset_out(sys_reset_out),
    .ext_reset_sel_in(ext_reset_sel_in), .port_b_bit3_pullup_out(port_b_bit3_pullup_out),
    .port_b_bit3_oe_out(port_b_bit3_oe_out), .osc_mode_in(osc_mode_in),
    .cycle_rate_out_en_in(cycle_rate_out_en_in), .osc_out_pin_out(osc_out_pin_out),
    .osc_out_pin_oe_out(osc_out_pin_oe_out));

  always #25 ref_clk_in = ~ref_clk_in;

  function automatic logic [12:0] wd(input logic [9:0] a);
    wd = {3'h5, a};
  endfunction : wd

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic close_out();
    $display("checks=%0d mismatches=%0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : close_out

  task automatic wait_valid();
    for (int i = 0; i < 12 && instr_valid_out !== 1'b1; i++) @(negedge ref_clk_in);
  endtask : wait_valid

  // Kinds: 0 jump, 1 call, 2 return, 3 software interrupt
  task automatic br(input int k, input logic [9:0] t, input logic [9:0] e);
    {jump_in, call_in, ret_in, swi_in} = 4'(8 >> k);
    target_in = t;
    @(negedge ref_clk_in);
    {jump_in, call_in, ret_in, swi_in} = 4'h0;
    chk(prog_addr_out, e);
    chk(instr_valid_out, 1'b0);
    @(negedge ref_clk_in);
    chk(instr_out, wd(e));
    chk(prog_addr_out, 10'(e + 10'h001));
    pc_exp = e + 10'h001;
  endtask : br

  task automatic t_flow();
    wait_valid();
    chk(instr_out, wd(`PSV_RESET_VEC));
    chk(prog_addr_out, 10'h000);
    @(negedge ref_clk_in);
    chk(instr_out, wd(10'h000));
    br(0, 10'h3fe, 10'h3fe);
    @(negedge ref_clk_in);
    chk(instr_out, wd(10'h3ff));
    chk(prog_addr_out, 10'h000);
    pc_exp = 10'h000;
    for (int i = 0; i < 5; i++) begin
      stk.push_back(pc_exp);
      br(1, 10'(100 * i + 40), 10'(100 * i + 40));
    end
    for (int i = 0; i < 5; i++) br(2, 10'h000, stk.pop_back());
    stk.push_back(pc_exp);
    br(3, 10'h000, `PSV_SW_VEC);
    br(2, 10'h000, stk.pop_back());
  endtask : t_flow

  task automatic t_irq();
    gie_in = 1'b1;
    tick_run = 1'b1;
    for (int i = 0; i < 12 && int_taken_out !== 1'b1; i++) begin
      @(negedge ref_clk_in);
      pc_exp = pc_exp + 10'h001;
    end
    tick_run = 1'b0;
    chk(int_taken_out, 1'b1);
    chk(int_flags_out, 3'h1);
    stk.push_back(pc_exp);
    @(negedge ref_clk_in);
    gie_in = 1'b0;
    flag_clr_in = 3'h1;
    chk(prog_addr_out, `PSV_HW_VEC);
    @(negedge ref_clk_in);
    flag_clr_in = 3'h0;
    chk(instr_out, wd(`PSV_HW_VEC));
    br(2, 10'h000, stk.pop_back());
  endtask : t_irq

  task automatic t_sleep();
    sleep_in = 1'b1;
    @(negedge ref_clk_in);
    sleep_in = 1'b0;
    repeat (3) @(negedge ref_clk_in);
    chk(sleeping_out, 1'b1);
    chk(instr_valid_out, 1'b0);
    port_b_in[3] = 1'b1;
    wait_valid();
    chk(instr_out, wd(pc_exp));
    chk(port_b_bit3_oe_out, 1'b0);
  endtask : t_sleep

  task automatic src(input logic [7:0] b, input logic [2:0] f);
    flag_clr_in = 3'h7;
    @(negedge ref_clk_in);
    flag_clr_in = 3'h0;
    port_b_in = b;
    for (int i = 0; i < 8 && int_flags_out !== f; i++) @(negedge ref_clk_in);
    chk(int_flags_out, f);
  endtask : src

  task automatic t_osc();
    logic o;
    cycle_rate_out_en_in = 1'b1;
    for (int m = 0; m < 4; m++) begin
      osc_mode_in = 2'(m);
      @(negedge ref_clk_in);
      o = osc_out_pin_out;
      @(negedge ref_clk_in);
      chk(osc_out_pin_oe_out, m != 3);
      if (m < 3) chk(osc_out_pin_out, !o);
      else chk(osc_out_pin_out, 1'b0);
    end
  endtask : t_osc

  // Kinds: 0 power-on, 1 brown-out, 2 watchdog, 3 reset pin
  task automatic rs(input int k);
    ext_reset_sel_in = 1'b1;
    {por_rst_in, bor_rst_in, wdt_rst_in} = 3'(4 >> k);
    if (k == 3) port_b_in[3] = 1'b0;
    repeat (4) @(negedge ref_clk_in);
    chk(port_b_bit3_pullup_out, 1'b1);
    chk(sys_reset_out, 1'b1);
    chk(prog_addr_out, `PSV_RESET_VEC);
    {por_rst_in, bor_rst_in, wdt_rst_in} = 3'h0;
    port_b_in[3] = 1'b1;
    wait_valid();
    chk(instr_out, wd(`PSV_RESET_VEC));
  endtask : rs

  initial begin
    ref_clk_in = 1'b0;
    nrst_in = 1'b0;
    {por_rst_in, bor_rst_in, wdt_rst_in, jump_in, call_in, ret_in, swi_in, sleep_in} = 8'h00;
    {int_edge_rise_in, gie_in, ext_reset_sel_in, cycle_rate_out_en_in, tick_run} = 5'h10;
    {target_in, pc_exp, port_b_in, port_b_wake_en_in} = {10'h000, 10'h000, 8'h00, 8'h0a};
    {int_en_in, flag_clr_in, osc_mode_in} = {3'h1, 3'h0, 2'h3};
    repeat (6) @(negedge ref_clk_in);
    nrst_in = 1'b1;
    t_flow();
    $display("flow test done");
    t_irq();
    $display("interrupt test done");
    t_sleep();
    $display("sleep test done");
    src(8'h09, 3'h4);
    src(8'h0b, 3'h2);
    // Falling-edge mode on the external pin
    int_edge_rise_in = 1'b0;
    src(8'h0a, 3'h4);
    $display("source test done");
    t_osc();
    $display("oscillator test done");
    for (int k = 0; k < 4; k++) rs(k);
    $display("reset test done");
    close_out();
  end

  // Tests need about 100 cycles
  initial begin
    #(3000 * 50);
    miscompares++;
    close_out();
  end
endmodule : tb_program_sequencer_vectors

`default_nettype wire
